// ==== rtl/glu_pkg.sv ====
package glu_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int ACK_RD_SLOW_NS = 350;
    localparam int ACK_RD_FAST_NS = 250;
    localparam int VEC_SLOW_NS = 250;
    localparam int VEC_FAST_NS = 180;
    localparam int IO_WAIT_STATES = 1;
    localparam int SHIFT_DEPTH = 64;
    localparam int CHAIN_EXTRA = 0;

    // Least time in whole cycles, never below one
    function automatic int min_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : min_cycles

    localparam int ACK_RD_SLOW_CYC = min_cycles(ACK_RD_SLOW_NS);
    localparam int ACK_RD_FAST_CYC = min_cycles(ACK_RD_FAST_NS);
    localparam int VEC_SLOW_CYC = min_cycles(VEC_SLOW_NS);
    localparam int VEC_FAST_CYC = min_cycles(VEC_FAST_NS);

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic cpu_clk;
        logic fetch_n;
        logic mem_request_n;
        logic io_request_n;
        logic rd_n;
        logic wr_n;
        logic sel;
        logic pclk;
        logic sys_rst_n;
        logic fast;
        logic delay_strobe;
        logic wait_all;
        logic sync_pclk;
    } glu_pins_s;

    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic ack_n;
        logic wait_n;
    } glu_out_s;

    typedef enum logic [1:0] {ACK_IDLE, ACK_SYNC, ACK_RUN} glu_ack_e;

endpackage : glu_pkg

// ==== rtl/glu_sync.sv ====
`timescale 1ns/100ps
module glu_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    initial begin
        if (W < 1) $error("glu_sync: W must be at least 1");
    end

    // Three stages; s1 feeds only s2 to keep metastability contained
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1 <= '1;
            s2 <= '1;
            s3 <= '1;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // A bit changes only once stages two and three agree
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '1;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2[i] == s3[i]) q[i] <= s3[i];
            end
        end
    end

endmodule : glu_sync

// ==== rtl/glu_shift.sv ====
`timescale 1ns/100ps
module glu_shift #(
    parameter int DEPTH = 64
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             clear,
    input  wire logic             run,
    output logic      [DEPTH-1:0] taps
);

    initial begin
        if (DEPTH < 2) $error("glu_shift: DEPTH must be at least 2");
    end

    // Ones walk in while running; each tap is a delayed start
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            taps <= '0;
        end else if (clear) begin
            taps <= '0;
        end else if (run) begin
            taps <= {taps[DEPTH-2:0], 1'b1};
        end
    end

endmodule : glu_shift

// ==== rtl/glu_top.sv ====
`timescale 1ns/100ps
module glu_top #(
    parameter int WAIT_STATES = glu_pkg::IO_WAIT_STATES,
    parameter int CHAIN_EXTRA = glu_pkg::CHAIN_EXTRA,
    parameter int DEPTH       = glu_pkg::SHIFT_DEPTH
) (
    input  wire logic CLK_SYS,
    input  wire logic RESET_N,
    input  wire logic CPU_CLK,
    input  wire logic CPU_FETCH_N,
    input  wire logic CPU_MEM_REQUEST_N,
    input  wire logic CPU_IO_REQUEST_N,
    input  wire logic CPU_RD_N,
    input  wire logic CPU_WR_N,
    input  wire logic PERIPH_SEL,
    input  wire logic PCLK,
    input  wire logic SYS_RESET_N,
    input  wire logic FAST_GRADE,
    input  wire logic DELAY_STROBE,
    input  wire logic WAIT_ALL_IO,
    input  wire logic SYNC_TO_PCLK,
    output logic      PERIPH_RD_N,
    output logic      PERIPH_WR_N,
    output logic      INTR_ACK_STROBE_N,
    output logic      CPU_WAIT_N
);

    localparam int IW = $clog2(DEPTH);
    localparam int CW = 8;

    glu_pkg::glu_pins_s pins_raw;
    glu_pkg::glu_pins_s pins;
    glu_pkg::glu_out_s  out;
    glu_pkg::glu_out_s  next_out;
    glu_pkg::glu_ack_e  state;
    glu_pkg::glu_ack_e  next_state;
    logic [DEPTH-1:0]   taps;
    logic               cpu_clk_q;
    logic               pclk_q;
    logic               cpu_rise;
    logic               pclk_rise;
    logic               io_cyc;
    logic               rel;
    logic [CW-1:0]      wcnt;
    logic               io_wait;
    logic [IW-1:0]      rd_idx;
    logic [IW-1:0]      end_idx;
    logic               ack_rd;
    logic               ack_wait;

    initial begin
        if (WAIT_STATES < 0 || WAIT_STATES > 255) $error("glu_top: bad WAIT_STATES");
        if (CHAIN_EXTRA < 0) $error("glu_top: bad CHAIN_EXTRA");
        if (DEPTH <= glu_pkg::ACK_RD_SLOW_CYC + glu_pkg::VEC_SLOW_CYC + CHAIN_EXTRA)
            $error("glu_top: DEPTH too small for acknowledge taps");
    end

    // ------------------------------------------------------------
    // Pin capture
    // ------------------------------------------------------------
    // Every pin is foreign to CLK_SYS, straps included
    assign pins_raw = '{cpu_clk: CPU_CLK, fetch_n: CPU_FETCH_N,
                        mem_request_n: CPU_MEM_REQUEST_N, io_request_n: CPU_IO_REQUEST_N,
                        rd_n: CPU_RD_N, wr_n: CPU_WR_N, sel: PERIPH_SEL,
                        pclk: PCLK, sys_rst_n: SYS_RESET_N,
                        fast: FAST_GRADE, delay_strobe: DELAY_STROBE,
                        wait_all: WAIT_ALL_IO, sync_pclk: SYNC_TO_PCLK};

    glu_sync #(
        .W($bits(glu_pkg::glu_pins_s))
    ) u_sync (
        .clk    (CLK_SYS),
        .reset_n(RESET_N),
        .d      (pins_raw),
        .q      (pins)
    );

    // Clock edges seen on the filtered copies
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            cpu_clk_q <= 1'b1;
            pclk_q    <= 1'b1;
        end else begin
            cpu_clk_q <= pins.cpu_clk;
            pclk_q    <= pins.pclk;
        end
    end

    assign cpu_rise  = pins.cpu_clk & ~cpu_clk_q;
    assign pclk_rise = pins.pclk & ~pclk_q;

    // ------------------------------------------------------------
    // Acknowledge sequencer
    // ------------------------------------------------------------
    // Vector read is gated only by strobe plus read, so no return-op decode
    always_comb begin
        next_state = state;
        case (state)
            glu_pkg::ACK_IDLE: begin
                if (cpu_rise && !pins.fetch_n && pins.mem_request_n) begin
                    next_state = pins.sync_pclk ? glu_pkg::ACK_SYNC
                                                : glu_pkg::ACK_RUN;
                end
            end
            glu_pkg::ACK_SYNC: begin
                if (pins.fetch_n) next_state = glu_pkg::ACK_IDLE;
                else if (pclk_rise) next_state = glu_pkg::ACK_RUN;
            end
            glu_pkg::ACK_RUN: begin
                if (pins.fetch_n) next_state = glu_pkg::ACK_IDLE;
            end
            default: next_state = glu_pkg::ACK_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) state <= glu_pkg::ACK_IDLE;
        else          state <= next_state;
    end

    // Shift chain stays cleared unless an acknowledge is running
    glu_shift #(
        .DEPTH(DEPTH)
    ) u_shift (
        .clk    (CLK_SYS),
        .reset_n(RESET_N),
        .clear  (state != glu_pkg::ACK_RUN),
        .run    (state == glu_pkg::ACK_RUN),
        .taps   (taps)
    );

    // Tap choice follows the peripheral grade; extra chain time adds on
    always_comb begin
        rd_idx  = IW'(CHAIN_EXTRA) + (pins.fast ? IW'(glu_pkg::ACK_RD_FAST_CYC)
                                                : IW'(glu_pkg::ACK_RD_SLOW_CYC));
        end_idx = rd_idx + (pins.fast ? IW'(glu_pkg::VEC_FAST_CYC)
                                      : IW'(glu_pkg::VEC_SLOW_CYC));
    end

    assign ack_rd   = taps[rd_idx];
    assign ack_wait = (state != glu_pkg::ACK_IDLE) && !taps[end_idx];

    // ------------------------------------------------------------
    // I/O wait states and strobe retiming
    // ------------------------------------------------------------
    // Strap chooses all I/O cycles or only selected peripherals
    assign io_cyc = !pins.io_request_n && pins.fetch_n && (!pins.rd_n || !pins.wr_n)
                    && (pins.sel || pins.wait_all);

    // Strobe release waits for a CPU clock rise when delaying
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) rel <= 1'b0;
        else if (!io_cyc) rel <= 1'b0;
        else if (cpu_rise || !pins.delay_strobe) rel <= 1'b1;
    end

    // One counter for reads and writes keeps the two identical
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            wcnt <= '0;
        end else if (!io_cyc) begin
            wcnt <= '0;
        end else if (rel && cpu_rise && wcnt < CW'(WAIT_STATES)) begin
            wcnt <= wcnt + CW'(1);
        end
    end

    assign io_wait = io_cyc && (wcnt < CW'(WAIT_STATES));

    // ------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------
    // Strobe gated by state: the chain clears one edge late, the strobe must not
    always_comb begin
        next_out.ack_n  = !(taps[0] && state == glu_pkg::ACK_RUN);
        next_out.wait_n = !(io_wait || ack_wait);
        if (!pins.sys_rst_n) begin
            next_out.rd_n = 1'b0;
            next_out.wr_n = 1'b0;
        end else if (state != glu_pkg::ACK_IDLE) begin
            next_out.rd_n = !ack_rd;
            next_out.wr_n = 1'b1;
        end else begin
            next_out.rd_n = pins.rd_n || (io_cyc && !rel);
            next_out.wr_n = pins.wr_n || (io_cyc && !rel);
        end
    end

    // Reset value shows the peripheral reset pattern at once
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) out <= '{rd_n: 1'b0, wr_n: 1'b0, ack_n: 1'b1, wait_n: 1'b1};
        else          out <= next_out;
    end

    assign PERIPH_RD_N       = out.rd_n;
    assign PERIPH_WR_N       = out.wr_n;
    assign INTR_ACK_STROBE_N = out.ack_n;
    assign CPU_WAIT_N        = out.wait_n;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [CW-1:0] ack_cnt;
    logic [CW-1:0] rd_cnt;

    // Cycles since the strobe, and since acknowledge read
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            ack_cnt <= '0;
            rd_cnt  <= '0;
        end else begin
            ack_cnt <= !taps[0] ? '0 : (&ack_cnt ? ack_cnt : ack_cnt + CW'(1));
            if (state == glu_pkg::ACK_IDLE || out.rd_n) rd_cnt <= '0;
            else if (!(&rd_cnt)) rd_cnt <= rd_cnt + CW'(1);
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);

    sequence s_ack_seen;
        state == glu_pkg::ACK_IDLE && cpu_rise && !pins.fetch_n && pins.mem_request_n;
    endsequence

    sequence s_io_held;
        state == glu_pkg::ACK_IDLE && pins.sys_rst_n && io_cyc && !rel;
    endsequence

    a_ack_detect:
        assert property (s_ack_seen |=> state != glu_pkg::ACK_IDLE)
        else $error("acknowledge not detected");

    a_pclk_align:
        assert property (state == glu_pkg::ACK_SYNC ##1 state == glu_pkg::ACK_SYNC
                         |-> out.ack_n)
        else $error("acknowledge strobe before peripheral clock");

    a_ack_order:
        assert property ($fell(out.ack_n) |-> out.rd_n)
        else $error("acknowledge read came with strobe");

    a_ack_rd_delay:
        assert property (state == glu_pkg::ACK_RUN && $fell(out.rd_n) |->
                         ack_cnt > CW'(pins.fast ? glu_pkg::ACK_RD_FAST_CYC
                                                 : glu_pkg::ACK_RD_SLOW_CYC))
        else $error("acknowledge read too early");

    a_vector_wait:
        assert property (state == glu_pkg::ACK_RUN && !out.rd_n &&
                         rd_cnt < CW'(pins.fast ? glu_pkg::VEC_FAST_CYC
                                                : glu_pkg::VEC_SLOW_CYC)
                         |-> !out.wait_n)
        else $error("wait released before vector valid");

    a_seq_cleared:
        assert property (state == glu_pkg::ACK_IDLE |=> taps == '0 && out.ack_n)
        else $error("sequencer not cleared");

    a_io_wait_held:
        assert property (s_io_held |=> !out.wait_n)
        else $error("no wait during peripheral cycle");

    a_strobe_retime:
        assert property (s_io_held |=> out.rd_n && out.wr_n)
        else $error("strobe released before clock rise");

    a_reset_strobes:
        assert property (!pins.sys_rst_n |=> !out.rd_n && !out.wr_n)
        else $error("reset not passed to peripherals");

    // CPU must already be held while the strobe waits for the peripheral clock
    a_sync_wait:
        assert property (state == glu_pkg::ACK_SYNC |=> !out.wait_n)
        else $error("no wait while aligning to peripheral clock");

    // Holding wait longer than the vector needs only costs CPU time
    a_wait_release:
        assert property (state == glu_pkg::ACK_RUN && !out.rd_n &&
                         rd_cnt >= CW'(pins.fast ? glu_pkg::VEC_FAST_CYC
                                                 : glu_pkg::VEC_SLOW_CYC)
                         |-> out.wait_n)
        else $error("wait held past vector valid");

    // Acknowledge is a read; a write strobe now would look like a reset
    a_ack_no_write:
        assert property (state != glu_pkg::ACK_IDLE && pins.sys_rst_n |=> out.wr_n)
        else $error("write strobe during acknowledge");

endmodule : glu_top

// ==== tb/glu_periph_model.sv ====
`timescale 1ns/100ps
module glu_periph_model (
    input  wire logic        clk,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic        ack_n,
    output logic      [15:0] ack_rd_cyc,
    output logic             in_service
);
    // Strobe-to-read spacing, held until the strobe ends
    always_ff @(posedge clk) begin
        if (ack_n)
            ack_rd_cyc <= 16'h0000;
        else if (rd_n)
            ack_rd_cyc <= ack_rd_cyc + 16'h0001;
    end
    // Set by the acknowledge read; only the reset pattern clears it
    always_ff @(posedge clk) begin
        if (!rd_n && !wr_n)
            in_service <= 1'b0;
        else if (!ack_n && !rd_n)
            in_service <= 1'b1;
    end
endmodule : glu_periph_model

// ==== tb/glu_top_tb.sv ====
`timescale 1ns/100ps
module glu_top_tb;
    localparam int CHAIN = 4;
    logic clk_sys = 1'b0, reset_n = 1'b0, cpu_clk = 1'b0;
    logic fetch_n = 1'b1, mem_req_n = 1'b1, io_req_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
    logic sel = 1'b0, sys_rst_n = 1'b1, fast = 1'b1, dly = 1'b0, wall = 1'b0;
    logic sync_p = 1'b0;
    logic p_rd_n, p_wr_n, ack_n, wait_n, in_svc;
    logic [15:0] ack_cyc, n;
    int fails = 0, tests_run = 0, cycles = 0, cdiv = 0;

    // ----------------------------------------
    // Clocks and timeout
    // ----------------------------------------
    always #5 clk_sys = ~clk_sys;
    // CPU clock far slower than the system clock, as the sampler needs
    always @(posedge clk_sys) begin
        #1;
        cdiv = (cdiv == 9) ? 0 : cdiv + 1;
        if (cdiv == 0) cpu_clk = ~cpu_clk;
        cycles++;
        if (cycles == 30000) begin
            fails++;
            stop_test();
        end
    end

    // Extra chain time needs a deeper shift register than the default
    glu_top #(.CHAIN_EXTRA(CHAIN), .DEPTH(72)) i_glu_top (
        .CLK_SYS(clk_sys), .RESET_N(reset_n), .CPU_CLK(cpu_clk),
        .CPU_FETCH_N(fetch_n), .CPU_MEM_REQUEST_N(mem_req_n), .CPU_IO_REQUEST_N(io_req_n),
        .CPU_RD_N(rd_n), .CPU_WR_N(wr_n), .PERIPH_SEL(sel), .PCLK(cpu_clk),
        .SYS_RESET_N(sys_rst_n), .FAST_GRADE(fast), .DELAY_STROBE(dly),
        .WAIT_ALL_IO(wall), .SYNC_TO_PCLK(sync_p), .PERIPH_RD_N(p_rd_n),
        .PERIPH_WR_N(p_wr_n), .INTR_ACK_STROBE_N(ack_n), .CPU_WAIT_N(wait_n));

    glu_periph_model i_glu_periph_model (
        .clk(clk_sys), .rd_n(p_rd_n), .wr_n(p_wr_n), .ack_n(ack_n),
        .ack_rd_cyc(ack_cyc), .in_service(in_svc));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : tick

    function automatic logic pick(input int s);
        case (s)
            0: return p_rd_n;
            1: return p_wr_n;
            2: return ack_n;
            default: return wait_n;
        endcase
    endfunction : pick

    // Bounded wait for an output level, edges counted
    task automatic wait_sig(input int s, input logic lvl, output logic [15:0] c);
        c = 16'h0000;
        while (pick(s) !== lvl && c < 16'h00C8) begin
            tick(1);
            c = c + 16'h0001;
        end
    endtask : wait_sig

    task automatic check_eq(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_eq

    task automatic check_range(input logic [15:0] got, input int lo, input int hi);
        tests_run++;
        if ($isunknown(got) || got < lo || got > hi) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : check_range

    task automatic align_cpu();
        @(posedge cpu_clk);
        tick(1);
    endtask : align_cpu

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic reset_test();
        tick(1);
        check_eq({p_rd_n, p_wr_n, ack_n}, 16'h0001);
        reset_n = 1'b1;
        tick(3);
        check_eq({p_rd_n, p_wr_n, ack_n, wait_n}, 16'h000F);
        sys_rst_n = 1'b0;
        wait_sig(0, 1'b0, n);
        check_range(n, 1, 8);
        check_eq({p_wr_n, in_svc}, 16'h0000);
        sys_rst_n = 1'b1;
        tick(8);
    endtask : reset_test

    task automatic pass_test();
        io_req_n = 1'b0;
        rd_n = 1'b0;
        wait_sig(0, 1'b0, n);
        check_range(n, 1, 8);
        check_eq(wait_n, 1'b1);
        wall = 1'b1;
        wait_sig(3, 1'b0, n);
        check_range(n, 1, 8);
        io_req_n = 1'b1;
        rd_n = 1'b1;
        wall = 1'b0;
        tick(30);
    endtask : pass_test

    task automatic io_cycle(input int s);
        align_cpu();
        dly = 1'b1;
        sel = 1'b1;
        io_req_n = 1'b0;
        if (s == 1) wr_n = 1'b0;
        else rd_n = 1'b0;
        tick(10);
        check_eq({pick(s), wait_n}, 16'h0002);
        wait_sig(s, 1'b0, n);
        check_range(n, 8, 18);
        wait_sig(3, 1'b1, n);
        check_range(n, 17, 23);
        io_req_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        wait_sig(s, 1'b1, n);
        check_range(n, 1, 8);
        sel = 1'b0;
        dly = 1'b0;
        tick(30);
    endtask : io_cycle

    task automatic fetch_test();
        align_cpu();
        fetch_n = 1'b0;
        mem_req_n = 1'b0;
        tick(40);
        check_eq({ack_n, wait_n, p_rd_n}, 16'h0007);
        fetch_n = 1'b1;
        mem_req_n = 1'b1;
        tick(10);
    endtask : fetch_test

    task automatic ack_test(input logic g, input logic sy);
        fast = g;
        sync_p = sy;
        tick(10);
        align_cpu();
        fetch_n = 1'b0;
        tick(10);
        check_eq(wait_n, 1'b1);
        wait_sig(3, 1'b0, n);
        check_range(n, 8, 18);
        wait_sig(2, 1'b0, n);
        if (sy) check_range(n, 18, 22);
        else check_eq(n, 16'h0001);
        wait_sig(0, 1'b0, n);
        check_eq(ack_cyc, g ? glu_pkg::ACK_RD_FAST_CYC + CHAIN
                            : glu_pkg::ACK_RD_SLOW_CYC + CHAIN);
        check_eq(wait_n, 1'b0);
        wait_sig(3, 1'b1, n);
        check_eq(n, g ? glu_pkg::VEC_FAST_CYC : glu_pkg::VEC_SLOW_CYC);
        check_eq(in_svc, 1'b1);
        fetch_n = 1'b1;
        wait_sig(2, 1'b1, n);
        check_range(n, 1, 8);
        check_eq({p_rd_n, wait_n}, 16'h0003);
        sys_rst_n = 1'b0;
        wait_sig(0, 1'b0, n);
        tick(1);
        check_eq(in_svc, 1'b0);
        sys_rst_n = 1'b1;
        tick(10);
    endtask : ack_test

    task automatic stop_test();
        if (fails == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        tick(2);
        reset_test();
        pass_test();
        io_cycle(0);
        io_cycle(1);
        fetch_test();
        ack_test(1'b1, 1'b0);
        ack_test(1'b0, 1'b0);
        ack_test(1'b1, 1'b1);
        stop_test();
    end
endmodule : glu_top_tb
